// ==== hvsu_pkg.sv ====
// Purpose: shared constants and types for the step-up converter control block
// Assumes: 10 MHz system clock, 8-bit register data
// Notes: register addresses are the microcontroller-side word addresses
package hvsu_pkg;
  localparam logic [15:0] HVSU_ADDR_VOUT = 16'ha088;
  localparam logic [15:0] HVSU_ADDR_CTRL = 16'ha089;
  // output-voltage register layout
  localparam int HVSU_VOUT_LSB = 0;
  localparam int HVSU_VOUT_MSB = 4;
  localparam int HVSU_LEN_BIT = 7;
  localparam logic [4:0] HVSU_VOUT_RST = 5'h13;
  localparam logic [7:0] HVSU_VOUT_REG_RST = 8'h13;
  // control register layout
  localparam int HVSU_FSEL_BIT = 1;
  localparam int HVSU_ILIM_LSB = 2;
  localparam int HVSU_ILIM_MSB = 3;
  localparam int HVSU_OUTPUT_OK_FLAG_BIT = 5;
  localparam logic [7:0] HVSU_CTRL_RST = 8'h0e;
  localparam logic [7:0] HVSU_CTRL_WMASK = 8'hdf;
  // soft-start current-limited interval
  localparam int HVSU_CLK_HZ = 10_000_000;
  localparam int HVSU_SS_US = 500;
  localparam int HVSU_SS_CYC = HVSU_SS_US * (HVSU_CLK_HZ / 1_000_000);
  localparam logic [12:0] HVSU_SS_LAST = 13'(HVSU_SS_CYC - 1);
  typedef enum logic [1:0] {HVSU_OFF, HVSU_SOFT, HVSU_RUN} hvsu_state_e;
endpackage

// ==== hvsu_seq_if.sv ====
// Purpose: carries enable and status between register bank and sequencer
// Assumes: single clock domain
// Notes: none
`timescale 1ns/10ps
`default_nettype none
interface hvsu_seq_if;
  logic run_req;
  logic running;
  logic soft_start;
  modport bank (output run_req, input running, input soft_start);
  modport seq (input run_req, output running, output soft_start);
endinterface
`default_nettype wire

// ==== hvsu_seq.sv ====
// Purpose: on/off and soft-start sequencer for the step-up converter
// Assumes: run request already combines both enables; reset acts through i_rstn
// Notes: restart of the request reopens the soft-start interval
`timescale 1ns/10ps
`default_nettype none
module hvsu_seq
  import hvsu_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_ce,
  // link to register bank
  hvsu_seq_if.seq sq
);
  typedef struct packed {
    hvsu_state_e state;
    logic [12:0] cnt;
  } hvsu_seq_s;
  hvsu_seq_s r;
  hvsu_seq_s next_r;

  always_comb begin
    next_r = r;
    unique case (r.state)
      HVSU_OFF: begin
        next_r.cnt = 13'h0000;
        if (sq.run_req) begin
          next_r.state = HVSU_SOFT; // [R9]
        end
      end
      HVSU_SOFT: begin
        if (!sq.run_req) begin
          next_r.state = HVSU_OFF; // [R4]
        end else if (r.cnt == HVSU_SS_LAST) begin
          next_r.state = HVSU_RUN; // [R10]
        end else begin
          next_r.cnt = r.cnt + 13'h0001;
        end
      end
      HVSU_RUN: begin
        if (!sq.run_req) begin
          next_r.state = HVSU_OFF; // [R4]
        end
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      r <= '{state: HVSU_OFF, cnt: 13'h0000};
    end else if (i_ce) begin
      r <= next_r;
    end
  end

  assign sq.running = (r.state != HVSU_OFF);
  assign sq.soft_start = (r.state == HVSU_SOFT); // [R10]
endmodule
`default_nettype wire

// ==== hvsu_ctrl.sv ====
// Purpose: register bank and enable logic of the on-chip 5 V step-up converter
// Assumes: simple synchronous register port, i_rstn is the internal power-on reset
// Notes: analog power stage sits outside; this block drives its settings
//
// Overview of operation
// [R1] control bit 1 selects 1.0 MHz when set, 0.5 MHz clear; resets set
// [R2] bits 3:2 pick 25/50/75/100 percent peak limit; reset value 11
// [R3] bit 5 reads power-good status, read-only, zero at reset
// [R4] converter runs only out of reset with global and local enables high
// [R5] power-on reset disables and loads defaults; disabling alone keeps settings
// [R6] defaults: local enable off, 5.0 V, 100 percent limit, 1 MHz
// [R7] raising global enable alone after reset does not start the converter
// [R8] software writes the voltage code together with every local enable change
// [R9] setting local enable starts soft-start ending at programmed voltage
// [R10] peak inductor current is restricted for first 500 us of soft-start
// [R11] voltage code may be changed while the converter runs
// [R12] voltage code may be changed during soft-start
// [R13] software uses global enable only for deep shutdown, local for on/off
// [R14] cycle-by-cycle current limit in normal run, lost when output below input
// [R15] voltage code bits 4:0 give code times 0.05 V plus 4.05 V
// [R16] local enable at bit 7 defaults zero; voltage code defaults 10011
// [R17] reserved control bits store writes harmlessly; power-good writes ignored
`timescale 1ns/10ps
`default_nettype none
module hvsu_ctrl
  import hvsu_pkg::*;
(
  // clock, reset, enable
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_ce,
  // register port
  input wire logic [15:0] i_addr,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  // system-level enable
  input wire logic i_global_en,
  // analog status
  input wire logic i_output_ok_flag,
  input wire logic i_vout_below_vin,
  // settings to the power stage
  output logic o_enable,
  output logic o_freq_high,
  output logic [1:0] o_peak_limit_code,
  output logic [4:0] o_vout_code,
  output logic o_soft_start,
  output logic o_cycle_limit_en
);
  typedef struct packed {
    logic [7:0] vout_reg;
    logic [7:0] ctrl_reg;
    logic gen_s1;
    logic gen_s2;
    logic ok_s1;
    logic ok_s2;
    logic low_s1;
    logic low_s2;
    logic [7:0] rdata;
    logic enable;
    logic freq_high;
    logic [1:0] peak_limit_code;
    logic [4:0] vout_code;
    logic soft_start;
    logic cycle_limit_en;
  } hvsu_ctrl_s;

  hvsu_ctrl_s r;
  hvsu_ctrl_s next_r;
  hvsu_seq_if sq_if ();

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  hvsu_seq u_seq (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_ce(i_ce),
    .sq(sq_if.seq)
  );

  // reset already holds the sequencer off, so only enables gate here
  assign sq_if.run_req = r.gen_s2 && r.vout_reg[HVSU_LEN_BIT]; // [R4] [R7]

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    next_r = r;
    // pins are asynchronous to i_clk: two stages each
    next_r.gen_s1 = i_global_en;
    next_r.gen_s2 = r.gen_s1;
    next_r.ok_s1 = i_output_ok_flag;
    next_r.ok_s2 = r.ok_s1;
    next_r.low_s1 = i_vout_below_vin;
    next_r.low_s2 = r.low_s1;
    // status bit mirrors synchronised power-good
    next_r.ctrl_reg[HVSU_OUTPUT_OK_FLAG_BIT] = r.ok_s2; // [R3]
    if (i_wr && (i_addr == HVSU_ADDR_VOUT)) begin
      // accepted in any sequencer state, no disable needed
      next_r.vout_reg = i_wdata; // [R11] [R12] [R16]
    end
    if (i_wr && (i_addr == HVSU_ADDR_CTRL)) begin
      next_r.ctrl_reg = (i_wdata & HVSU_CTRL_WMASK) |
                        (next_r.ctrl_reg & ~HVSU_CTRL_WMASK); // [R17]
    end
    if (i_rd) begin
      unique case (i_addr)
        HVSU_ADDR_VOUT: next_r.rdata = r.vout_reg;
        HVSU_ADDR_CTRL: next_r.rdata = r.ctrl_reg;
        default: next_r.rdata = 8'h00;
      endcase
    end
    next_r.enable = sq_if.running; // [R4]
    next_r.freq_high = r.ctrl_reg[HVSU_FSEL_BIT]; // [R1]
    next_r.peak_limit_code = r.ctrl_reg[HVSU_ILIM_MSB:HVSU_ILIM_LSB]; // [R2]
    next_r.vout_code = r.vout_reg[HVSU_VOUT_MSB:HVSU_VOUT_LSB]; // [R15] [R9]
    next_r.soft_start = sq_if.soft_start; // [R10]
    // limiting cannot act once the output sits below the input
    next_r.cycle_limit_en = sq_if.running && !r.low_s2; // [R14]
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      // defaults load only here, never on a plain disable
      r <= '0; // [R5]
      r.vout_reg <= HVSU_VOUT_REG_RST; // [R6] [R16]
      r.ctrl_reg <= HVSU_CTRL_RST; // [R6] [R1] [R2]
      r.freq_high <= HVSU_CTRL_RST[HVSU_FSEL_BIT];
      r.peak_limit_code <= HVSU_CTRL_RST[HVSU_ILIM_MSB:HVSU_ILIM_LSB];
      r.vout_code <= HVSU_VOUT_RST;
    end else if (i_ce) begin
      r <= next_r;
    end
  end

  assign o_rdata = r.rdata;
  assign o_enable = r.enable;
  assign o_freq_high = r.freq_high;
  assign o_peak_limit_code = r.peak_limit_code;
  assign o_vout_code = r.vout_code;
  assign o_soft_start = r.soft_start;
  assign o_cycle_limit_en = r.cycle_limit_en;
endmodule
`default_nettype wire

// ==== hvsu_host.sv ====
// Purpose: host-side register master model for the converter control block
// Assumes: one access every two clock edges
// Notes: released address and data lines show the inverse of their last value; strobes drop low
`timescale 1ns/10ps
`default_nettype none
module hvsu_host
  import hvsu_pkg::*;
(
  // clock
  input wire logic i_clk,
  // register port
  output var logic [15:0] o_addr = 16'h0000,
  output var logic o_wr = 1'b0,
  output var logic o_rd = 1'b0,
  output var logic [7:0] o_wdata = 8'h00
);
  task automatic acc(input logic [15:0] a, input logic [7:0] d, input logic w);
    @(posedge i_clk);
    o_addr <= a;
    o_wdata <= d;
    o_wr <= w;
    o_rd <= !w;
    @(posedge i_clk);
    o_wr <= 1'b0;
    o_rd <= 1'b0;
    o_addr <= ~a;
    o_wdata <= ~d;
  endtask
endmodule
`default_nettype wire

// ==== hvsu_ctrl_assertions.sv ====
// Purpose: port-level checks of the converter control block
// Assumes: clock enable high around every write that is checked
// Notes: settings land two samples after a write
`timescale 1ns/10ps
`default_nettype none
module hvsu_ctrl_assertions
  import hvsu_pkg::*;
(
  // clock and register port
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_ce,
  input wire logic [15:0] i_addr,
  input wire logic i_wr,
  input wire logic [7:0] i_wdata,
  // status inputs
  input wire logic i_global_en,
  input wire logic i_vout_below_vin,
  // settings
  input wire logic o_enable,
  input wire logic o_freq_high,
  input wire logic [1:0] o_peak_limit_code,
  input wire logic [4:0] o_vout_code,
  input wire logic o_soft_start,
  input wire logic o_cycle_limit_en
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  logic wc, wv;
  int ss_cnt;
  // a write seen while the clock enable is low is never taken
  assign wc = i_ce && i_wr && i_addr == HVSU_ADDR_CTRL;
  assign wv = i_ce && i_wr && i_addr == HVSU_ADDR_VOUT;
  // length of the running soft-start
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn)
      ss_cnt <= 0;
    else
      ss_cnt <= o_soft_start ? ss_cnt + 1 : 0;
  end
  property p_fs; wc |-> ##2 o_freq_high == $past(i_wdata[1], 2); endproperty
  a_fs: assert property (p_fs) else $error("freq select");
  property p_lim; wc |-> ##2 o_peak_limit_code == $past(i_wdata[3:2], 2); endproperty
  a_lim: assert property (p_lim) else $error("peak limit");
  property p_vo; wv |-> ##2 o_vout_code == $past(i_wdata[4:0], 2); endproperty
  a_vo: assert property (p_vo) else $error("vout code");
  property p_gl; !i_global_en [*8] |-> !o_enable; endproperty
  a_gl: assert property (p_gl) else $error("global off");
  property p_off; wv && !i_wdata[7] |-> ##4 !o_enable; endproperty
  a_off: assert property (p_off) else $error("local off");
  property p_ss; $rose(o_enable) |-> o_soft_start; endproperty
  a_ss: assert property (p_ss) else $error("no soft-start");
  property p_len; $fell(o_soft_start) && o_enable |-> ss_cnt == HVSU_SS_CYC; endproperty
  a_len: assert property (p_len) else $error("soft-start length");
  property p_cyc; i_vout_below_vin [*6] |-> !o_cycle_limit_en; endproperty
  a_cyc: assert property (p_cyc) else $error("cycle limit");
endmodule
bind hvsu_ctrl hvsu_ctrl_assertions i_hvsu_ctrl_assertions (.*);
`default_nettype wire

// ==== hvsu_ctrl_test.sv ====
// Purpose: self-checking bench for the converter control block
// Assumes: clock enable high except in the freeze scenario
// Notes: reads are checked against a queue of expected values
`timescale 1ns/10ps
`default_nettype none
module hvsu_ctrl_test;
  import hvsu_pkg::*;
  logic i_clk = 0, i_rstn = 0, i_ce = 1, i_global_en = 0, i_output_ok_flag = 0;
  logic i_vout_below_vin = 0, i_wr, i_rd, o_enable, o_freq_high, o_soft_start;
  logic o_cycle_limit_en, rd_pend = 0;
  logic [15:0] i_addr;
  logic [7:0] i_wdata, o_rdata, w, q[$];
  logic [1:0] o_peak_limit_code;
  logic [4:0] o_vout_code;
  int n_fail = 0, cmp_count = 0, cyc = 0, ss_n = 0;
  always #50 i_clk = ~i_clk;
  hvsu_ctrl i_hvsu_ctrl (.*);
  hvsu_host i_hvsu_host (.i_clk, .o_addr(i_addr), .o_wr(i_wr), .o_rd(i_rd), .o_wdata(i_wdata));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t: got %0h want %0h", $time, got, exp);
    end
  endtask
  task automatic chk_rd(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t: read %0h want %0h", $time, got, exp);
    end
  endtask
  task automatic rdx(input logic [15:0] a, input logic [7:0] e);
    q.push_back(e);
    i_hvsu_host.acc(a, 8'h00, 1'b0);
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d, input int n);
    i_hvsu_host.acc(a, d, 1'b1);
    repeat (n) @(posedge i_clk);
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  always @(posedge i_clk) begin
    if (rd_pend)
      chk_rd(o_rdata, q.pop_front());
    rd_pend <= i_rd;
    ss_n <= ss_n + int'(o_soft_start === 1'b1);
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      n_fail++;
      summarize();
    end
  end
  initial begin
    void'($urandom(84));
    repeat (4) @(posedge i_clk);
    i_rstn <= 1'b1;
    rdx(HVSU_ADDR_CTRL, HVSU_CTRL_RST);
    rdx(HVSU_ADDR_VOUT, HVSU_VOUT_REG_RST);
    rdx(16'ha08a, 8'h00);
    chk({o_freq_high, o_peak_limit_code, o_vout_code, o_enable},
        {3'h7, HVSU_VOUT_RST, 1'b0});
    i_global_en <= 1'b1;
    wr(16'ha08a, 8'h55, 8);
    chk(o_enable, 1'b0);
    for (int i = 0; i < 8; i++) begin
      w = 8'($urandom());
      w[3:2] = 2'(i);
      i_output_ok_flag <= i[2];
      wr(HVSU_ADDR_CTRL, w, 3);
      chk({o_freq_high, o_peak_limit_code}, {w[1], w[3:2]});
      rdx(HVSU_ADDR_CTRL, (w & HVSU_CTRL_WMASK) | {2'b00, i[2], 5'h00});
    end
    wr(HVSU_ADDR_VOUT, 8'h85, 0);
    wr(HVSU_ADDR_VOUT, 8'h9f, 4);
    chk({o_enable, o_soft_start, o_vout_code}, {2'b11, 5'h1f});
    repeat (5100) @(posedge i_clk);
    chk(ss_n, HVSU_SS_CYC);
    chk({o_enable, o_cycle_limit_en}, 2'b11);
    i_vout_below_vin <= 1'b1;
    wr(HVSU_ADDR_VOUT, 8'h8a, 8);
    chk({o_enable, o_cycle_limit_en, o_vout_code}, {2'b10, 5'h0a});
    // clock enable low: a write must not land
    i_ce <= 1'b0;
    wr(HVSU_ADDR_VOUT, 8'h95, 4);
    chk(o_vout_code, 5'h0a);
    i_ce <= 1'b1;
    i_vout_below_vin <= 1'b0;
    i_global_en <= 1'b0;
    repeat (10) @(posedge i_clk);
    chk(o_enable, 1'b0);
    i_global_en <= 1'b1;
    repeat (10) @(posedge i_clk);
    chk(o_enable, 1'b1);
    wr(HVSU_ADDR_VOUT, 8'h0a, 4);
    chk(o_enable, 1'b0);
    rdx(HVSU_ADDR_VOUT, 8'h0a);
    @(posedge i_clk);
    i_output_ok_flag <= 1'b0;
    i_rstn <= 1'b0;
    @(posedge i_clk);
    i_rstn <= 1'b1;
    rdx(HVSU_ADDR_VOUT, HVSU_VOUT_REG_RST);
    rdx(HVSU_ADDR_CTRL, HVSU_CTRL_RST);
    repeat (2) @(posedge i_clk);
    summarize();
  end
endmodule
`default_nettype wire
